// ### rtl/tlv_codec_pkg.sv
package tlv_codec_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAR = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_MINCLK = 8'h0c;
  localparam logic [7:0] ADDR_AVAIL = 8'h10;
  localparam logic [7:0] ADDR_DETAILS = 8'h14;
  localparam logic [7:0] ADDR_RESERVED = 8'h18;
  localparam logic [7:0] ADDR_MAXSIZE = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_DATA = 8'h24;
  // ctrl fields
  localparam int CTRL_START = 0;
  localparam int CTRL_EN_POWER = 1;
  localparam int CTRL_EN_MINCLK = 2;
  localparam int CTRL_EN_AVAIL = 3;
  localparam int CTRL_EN_DETAILS = 4;
  localparam int CTRL_EN_RESERVED = 5;
  // object tags
  localparam logic [7:0] TAG_TEMPLATE = 8'ha5;
  localparam logic [7:0] TAG_CHAR = 8'h80;
  localparam logic [7:0] TAG_POWER = 8'h81;
  localparam logic [7:0] TAG_MINCLK = 8'h82;
  localparam logic [7:0] TAG_AVAIL = 8'h83;
  localparam logic [7:0] TAG_DETAILS = 8'h84;
  localparam logic [7:0] TAG_RESERVED = 8'h85;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] LEN_POWER = 8'h03;
  localparam logic [7:0] LEN_SIZE = 8'h02;
  // field masks
  localparam logic [7:0] CHAR_MASK = 8'h7d;
  localparam logic [7:0] CURRENT_MASK = 8'h3f;
  localparam logic [7:0] DETAILS_MASK = 8'h01;
  localparam logic [7:0] FREQ_NONE = 8'hff;
  localparam logic [7:0] FREQ_MIN = 8'h0a;
  // reset values
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET = 8'hff;
  localparam logic [15:0] SIZE_RESET = 16'h0000;
  localparam logic [15:0] MAXSIZE_RESET = 16'hffff;
  localparam int MAX_BYTES = 32;
  localparam int MINCLK_SLOTS = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUILD = 2'b01,
    ST_DONE = 2'b10
  } build_state_e;
endpackage

// ### rtl/tlv_object_writer.sv
// emits one object (tag, length, value) as a byte list into a slot vector
module tlv_object_writer
  import tlv_codec_pkg::*;
(
  // object description
  input wire logic en,
  input wire logic [7:0] tag,
  input wire logic [7:0] len,
  input wire logic [31:0] value,
  // placement
  input wire logic [5:0] base,
  output logic [5:0] next_base,
  output logic [MAX_BYTES*8-1:0] bytes,
  output logic [MAX_BYTES-1:0] mask
);
  always_comb begin
    bytes = '0;
    mask = '0;
    next_base = base;
    if (en) begin
      bytes[base*8 +: 8] = tag;
      mask[base[4:0]] = 1'b1;
      bytes[(base+6'd1)*8 +: 8] = len;
      mask[5'(base+6'd1)] = 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (8'(i) < len) begin
          // value sent most significant byte first
          bytes[(base+6'd2+6'(i))*8 +: 8] = value[(int'(len)-1-i)*8 +: 8];
          mask[5'(base+6'd2+6'(i))] = 1'b1;
        end
      end
      next_base = 6'(base + 6'd2 + len[5:0]);
    end
  end
endmodule // tlv_object_writer

// ### rtl/tlv_property_encoder.sv
// Operation
// - characteristics object is tag 80, length 01, one value byte.
// - b1 set allows stop at any level; b3/b4 give preference.
// - b5, b6, b7 flag supply classes A, B, C.
// - reserved characteristics bits b8 and b2 forced to zero.
// - power object is tag 81, length 03: class, current, frequency.
// - current byte carries milliamperes in b6..b1, b8/b7 reserved zero.
// - reference frequency in 0.1 MHz from 0A; FF means none given.
// - current averaged over 1 ms at reference or maximum frequency.
// - minimum clock object tag 82, one byte; absent or FF means none.
// - several minimum clock objects kept in their given order.
// - available memory tag 83, length two, most significant byte first.
// - available size counts tag and length bytes of next object.
// - reported available size never exceeds the maximum file size.
// - file details tag 84, one byte; b1 distinguished encoding only.
// - reserved size tag 85, length two, most significant byte first.
// - reserved size includes overhead; zero when nothing reserved.
// - objects sit inside template A5; private objects may follow.
module tlv_property_encoder
  import tlv_codec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic [5:0] ctrl_en;
    logic [7:0] char_byte;
    logic [7:0] pw_class;
    logic [7:0] pw_current;
    logic [7:0] pw_freq;
    logic [MINCLK_SLOTS*8-1:0] minclk;
    logic [2:0] minclk_count;
    logic [15:0] avail;
    logic [7:0] details;
    logic [15:0] reserved;
    logic [15:0] maxsize;
    build_state_e state;
    logic [MAX_BYTES*8-1:0] image;
    logic [5:0] length;
    logic [5:0] rd_ptr;
    logic [31:0] rdata;
    logic err;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic access;
  logic [5:0] base [0:6];
  logic [MAX_BYTES*8-1:0] obj_bytes [0:5];
  logic [MAX_BYTES-1:0] obj_mask [0:5];
  logic [MAX_BYTES*8-1:0] body;
  logic [5:0] body_len;
  logic [15:0] avail_clip;
  logic [MINCLK_SLOTS*8-1:0] minclk_packed;

  function automatic logic [15:0] clip16(input logic [15:0] v, input logic [15:0] lim);
    clip16 = (v > lim) ? lim : v;
  endfunction

  function automatic logic [7:0] freq_code(input logic [7:0] v);
    freq_code = (v < FREQ_MIN) ? FREQ_NONE : v;
  endfunction

  assign access = psel && penable;
  assign avail_clip = clip16(cur.avail, cur.maxsize);
  assign minclk_packed = cur.minclk;

  // template body starts after tag A5 and its length byte
  assign base[0] = 6'd2;

  tlv_object_writer u_char (
    .en(1'b1),
    .tag(TAG_CHAR),
    .len(LEN_ONE),
    .value({24'h000000, cur.char_byte & CHAR_MASK}),
    .base(base[0]),
    .next_base(base[1]),
    .bytes(obj_bytes[0]),
    .mask(obj_mask[0])
  );

  tlv_object_writer u_power (
    .en(cur.ctrl_en[CTRL_EN_POWER]),
    .tag(TAG_POWER),
    .len(LEN_POWER),
    .value({8'h00, cur.pw_class, cur.pw_current & CURRENT_MASK,
      freq_code(cur.pw_freq)}),
    .base(base[1]),
    .next_base(base[2]),
    .bytes(obj_bytes[1]),
    .mask(obj_mask[1])
  );

  tlv_object_writer u_avail (
    .en(cur.ctrl_en[CTRL_EN_AVAIL]),
    .tag(TAG_AVAIL),
    .len(LEN_SIZE),
    .value({16'h0000, avail_clip}),
    .base(base[2]),
    .next_base(base[3]),
    .bytes(obj_bytes[2]),
    .mask(obj_mask[2])
  );

  tlv_object_writer u_details (
    .en(cur.ctrl_en[CTRL_EN_DETAILS]),
    .tag(TAG_DETAILS),
    .len(LEN_ONE),
    .value({24'h000000, cur.details & DETAILS_MASK}),
    .base(base[3]),
    .next_base(base[4]),
    .bytes(obj_bytes[3]),
    .mask(obj_mask[3])
  );

  tlv_object_writer u_reserved (
    .en(cur.ctrl_en[CTRL_EN_RESERVED]),
    .tag(TAG_RESERVED),
    .len(LEN_SIZE),
    .value({16'h0000, cur.reserved}),
    .base(base[4]),
    .next_base(base[5]),
    .bytes(obj_bytes[4]),
    .mask(obj_mask[4])
  );

  // minimum clock objects, grouped and kept in write order
  always_comb begin
    obj_bytes[5] = '0;
    obj_mask[5] = '0;
    base[6] = base[5];
    if (cur.ctrl_en[CTRL_EN_MINCLK]) begin
      for (int k = 0; k < MINCLK_SLOTS; k++) begin
        if (3'(k) < cur.minclk_count) begin
          obj_bytes[5][base[6]*8 +: 8] = TAG_MINCLK;
          obj_mask[5][base[6][4:0]] = 1'b1;
          obj_bytes[5][(base[6]+6'd1)*8 +: 8] = LEN_ONE;
          obj_mask[5][5'(base[6]+6'd1)] = 1'b1;
          obj_bytes[5][(base[6]+6'd2)*8 +: 8] = freq_code(minclk_packed[k*8 +: 8]);
          obj_mask[5][5'(base[6]+6'd2)] = 1'b1;
          base[6] = 6'(base[6] + 6'd3);
        end
      end
    end
  end

  always_comb begin
    body = '0;
    for (int o = 0; o < 6; o++) begin
      for (int b = 0; b < MAX_BYTES; b++) begin
        if (obj_mask[o][b]) begin
          body[b*8 +: 8] = obj_bytes[o][b*8 +: 8];
        end
      end
    end
    body[7:0] = TAG_TEMPLATE;
    body[15:8] = {2'b00, 6'(base[6] - 6'd2)};
    body_len = base[6];
  end

  always_comb begin
    next_cur = cur;
    next_cur.err = 1'b0;
    case (cur.state)
      ST_IDLE: begin
      end
      ST_BUILD: begin
        next_cur.image = body;
        next_cur.length = body_len;
        next_cur.rd_ptr = 6'd0;
        next_cur.state = ST_DONE;
      end
      ST_DONE: begin
      end
      default: next_cur.state = ST_IDLE;
    endcase
    if (access && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        next_cur.ctrl_en = pwdata[5:0];
        if (pwdata[CTRL_START]) begin
          next_cur.state = ST_BUILD;
        end
      end else if (paddr == ADDR_CHAR) begin
        next_cur.char_byte = pwdata[7:0];
      end else if (paddr == ADDR_POWER) begin
        next_cur.pw_class = pwdata[23:16];
        next_cur.pw_current = pwdata[15:8];
        next_cur.pw_freq = pwdata[7:0];
      end else if (paddr == ADDR_MINCLK) begin
        if (pwdata[31]) begin
          next_cur.minclk_count = 3'd0;
        end else if (cur.minclk_count < 3'(MINCLK_SLOTS)) begin
          next_cur.minclk[cur.minclk_count[1:0]*8 +: 8] = pwdata[7:0];
          next_cur.minclk_count = 3'(cur.minclk_count + 3'd1);
        end
      end else if (paddr == ADDR_AVAIL) begin
        next_cur.avail = pwdata[15:0];
      end else if (paddr == ADDR_DETAILS) begin
        next_cur.details = pwdata[7:0];
      end else if (paddr == ADDR_RESERVED) begin
        next_cur.reserved = pwdata[15:0];
      end else if (paddr == ADDR_MAXSIZE) begin
        next_cur.maxsize = pwdata[15:0];
      end else begin
        next_cur.err = 1'b1;
      end
    end
    if (access && !pwrite) begin
      next_cur.rdata = 32'h00000000;
      if (paddr == ADDR_CTRL) begin
        next_cur.rdata = {26'h0, cur.ctrl_en};
      end else if (paddr == ADDR_CHAR) begin
        next_cur.rdata = {24'h0, cur.char_byte & CHAR_MASK};
      end else if (paddr == ADDR_POWER) begin
        next_cur.rdata = {8'h0, cur.pw_class, cur.pw_current & CURRENT_MASK,
          freq_code(cur.pw_freq)};
      end else if (paddr == ADDR_MINCLK) begin
        next_cur.rdata = {29'h0, cur.minclk_count};
      end else if (paddr == ADDR_AVAIL) begin
        next_cur.rdata = {16'h0, avail_clip};
      end else if (paddr == ADDR_DETAILS) begin
        next_cur.rdata = {24'h0, cur.details & DETAILS_MASK};
      end else if (paddr == ADDR_RESERVED) begin
        next_cur.rdata = {16'h0, cur.reserved};
      end else if (paddr == ADDR_MAXSIZE) begin
        next_cur.rdata = {16'h0, cur.maxsize};
      end else if (paddr == ADDR_STATUS) begin
        next_cur.rdata = {16'h0, 2'b00, cur.length, 6'h0, cur.state};
      end else if (paddr == ADDR_DATA) begin
        // each read once the build is done pops the next response byte, until length bytes are read
        if (cur.state == ST_DONE && cur.rd_ptr < cur.length) begin
          next_cur.rdata = {23'h0, 1'b1, cur.image[cur.rd_ptr[4:0]*8 +: 8]};
          next_cur.rd_ptr = 6'(cur.rd_ptr + 6'd1);
        end
      end else begin
        next_cur.err = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{ctrl_en: 6'h00, char_byte: CHAR_RESET, pw_class: 8'h00,
        pw_current: 8'h00, pw_freq: FREQ_RESET, minclk: '0,
        minclk_count: 3'h0, avail: SIZE_RESET, details: 8'h00,
        reserved: SIZE_RESET, maxsize: MAXSIZE_RESET, state: ST_IDLE,
        image: '0, length: 6'h00, rd_ptr: 6'h00, rdata: 32'h00000000,
        err: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // zero-wait answer in the access phase
  assign pready = 1'b1;
  assign prdata = next_cur.rdata;
  assign pslverr = access && next_cur.err;
endmodule // tlv_property_encoder

// ### bench/tlv_codec_assertions.sv
module tlv_codec_assertions
  import tlv_codec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [5:0] pops;
  logic [15:0] maxsize;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_at(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence start_wr;
    psel && penable && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_START];
  endsequence
  // pops since the last control write, maximum size seen by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pops <= 6'h00;
      maxsize <= MAXSIZE_RESET;
    end else if (psel && penable && pwrite && paddr == ADDR_MAXSIZE) begin
      maxsize <= pwdata[15:0];
    end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
      pops <= 6'h00;
    end else if (psel && penable && !pwrite && paddr == ADDR_DATA) begin
      pops <= pops + 6'h01;
    end
  end
  ready_always_a: assert property (psel && penable |-> pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable && !pwrite && paddr > ADDR_DATA
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  char_reserved_a: assert property (rd_at(ADDR_CHAR) |-> prdata[7] == 1'b0 && prdata[1] == 1'b0)
    else $error("reserved characteristics bit set");
  current_field_a: assert property (rd_at(ADDR_POWER) |-> prdata[15:14] == 2'b00)
    else $error("current reserved bits set");
  ref_freq_a: assert property (rd_at(ADDR_POWER) |-> prdata[7:0] == FREQ_NONE || prdata[7:0] >= FREQ_MIN)
    else $error("reference frequency below range");
  details_field_a: assert property (rd_at(ADDR_DETAILS) |-> prdata[7:1] == 7'h00)
    else $error("details reserved bits set");
  avail_clip_a: assert property (rd_at(ADDR_AVAIL) |-> prdata[15:0] <= maxsize)
    else $error("available size above maximum");
  template_tag_a: assert property (rd_at(ADDR_DATA) ##0 (pops == 6'h00 && prdata[8])
    |-> prdata[7:0] == TAG_TEMPLATE) else $error("template tag wrong");
  char_header_a: assert property (rd_at(ADDR_DATA) ##0 (pops inside {6'h02, 6'h03})
    |-> prdata[7:0] == (pops == 6'h02 ? TAG_CHAR : LEN_ONE)) else $error("char header wrong");
  build_done_a: assert property (start_wr ##[3:6] rd_at(ADDR_STATUS) |-> prdata[1:0] == ST_DONE)
    else $error("build not done");
endmodule // tlv_codec_assertions

bind tlv_property_encoder tlv_codec_assertions i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ### bench/tlv_terminal_model.sv
module tlv_terminal_model
  import tlv_codec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // response bytes
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  // interpretation
  output logic [1:0] stop_mode,
  output logic current_ok,
  output logic [7:0] minclk_first,
  output logic [7:0] minclk_last
);
  logic [1:0] phase;
  logic [7:0] tag;
  logic [7:0] left;
  logic [7:0] idx;
  logic [2:0] count;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase = 2'd0;
      stop_mode = 2'd0;
      current_ok = 1'b0;
      count = 3'd0;
    end else if (byte_valid) begin
      case (phase)
        2'd0: begin
          tag = byte_in;
          phase = 2'd1;
        end
        2'd1: begin
          left = byte_in;
          idx = 8'h00;
          // constructed template is entered, its objects follow
          phase = (tag == TAG_TEMPLATE || byte_in == 8'h00) ? 2'd0 : 2'd2;
        end
        default: begin
          // 3 any level, 1 high only, 2 low only, 0 never
          if (tag == TAG_CHAR)
            stop_mode = byte_in[0] ? 2'd3 : byte_in[2] ? 2'd1 : byte_in[3] ? 2'd2 : 2'd0;
          if (tag == TAG_POWER && idx == 8'h01)
            // class byte is seen first; current checked against a fixed limit of 3C whatever the class
            current_ok = byte_in != 8'h00 && byte_in != 8'hff && byte_in <= 8'h3c;
          if (tag == TAG_MINCLK) begin
            if (count == 3'd0)
              minclk_first = byte_in;
            minclk_last = byte_in;
            count = count + 3'd1;
          end
          idx = idx + 8'h01;
          // any other tag is passed over by its length
          if (left == 8'h01)
            phase = 2'd0;
          left = left - 8'h01;
        end
      endcase
    end
  end
endmodule // tlv_terminal_model

// ### bench/testbench.sv
`define CHECK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tlv_codec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cur_ok;
  logic [7:0] paddr, f_first, f_last;
  logic [31:0] pwdata, prdata;
  logic [1:0] stop;
  logic [32:0] q_exp[$];
  logic [32:0] q_mask[$];
  string q_name[$];
  int miscompares, checks_done, cycles;
  tlv_property_encoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  tlv_terminal_model i_term (.pclk(pclk), .presetn(presetn),
    .byte_valid(psel && penable && !pwrite && paddr == ADDR_DATA && prdata[8]),
    .byte_in(prdata[7:0]), .stop_mode(stop), .current_ok(cur_ok), .minclk_first(f_first),
    .minclk_last(f_last));
  always #10 pclk = ~pclk;
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m, string n);
    q_exp.push_back(e & m);
    q_mask.push_back(m);
    q_name.push_back(n);
    apb(1'b0, a, 32'h0);
  endtask
  // monitor: each completed read is paired with the oldest note
  always @(posedge pclk) begin
    logic [32:0] m;
    logic [32:0] x;
    string nm;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
    if (presetn && psel && penable && !pwrite && pready && q_exp.size() > 0) begin
      m = q_mask.pop_front();
      x = q_exp.pop_front();
      nm = q_name.pop_front();
      `CHECK(nm, x, {pslverr, prdata} & m)
    end
  end
  initial begin
    logic [7:0] ch, cls, cur, fr, fe, det, f1, f2, e1, e2;
    logic [15:0] av, mx, rs, avc;
    logic [7:0] s[$];
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h10602045));
    for (int it = 0; it < 3; it++) begin
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_CHAR, 33'h0, 33'h1000000ff, "char reset");
      rd(ADDR_POWER, 33'hff, 33'h1000000ff, "freq reset");
      rd(ADDR_MAXSIZE, 33'hffff, 33'h10000ffff, "maxsize reset");
      rd(8'h3c, 33'h100000000, {33{1'b1}}, "unmapped");
      {ch, cls, cur, det, f1, f2} = {$urandom, $urandom};
      fr = (it == 0) ? 8'h05 : 8'($urandom);
      fe = (fr < FREQ_MIN) ? FREQ_NONE : fr;
      e1 = (f1 < FREQ_MIN) ? FREQ_NONE : f1;
      e2 = (f2 < FREQ_MIN) ? FREQ_NONE : f2;
      {av, mx} = $urandom;
      rs = (it == 0) ? 16'h0000 : 16'($urandom);
      avc = (av > mx) ? mx : av;
      apb(1'b1, ADDR_CHAR, {24'h0, ch});
      apb(1'b1, ADDR_POWER, {8'h0, cls, cur, fr});
      apb(1'b1, ADDR_MAXSIZE, {16'h0, mx});
      apb(1'b1, ADDR_AVAIL, {16'h0, av});
      apb(1'b1, ADDR_DETAILS, {24'h0, det});
      apb(1'b1, ADDR_RESERVED, {16'h0, rs});
      repeat (5) apb(1'b1, ADDR_MINCLK, $urandom & 32'hff);
      rd(ADDR_MINCLK, 33'h4, 33'h1000000ff, "minclk full");
      apb(1'b1, ADDR_MINCLK, 32'h80000000);
      apb(1'b1, ADDR_MINCLK, {24'h0, f1});
      apb(1'b1, ADDR_MINCLK, {24'h0, f2});
      rd(ADDR_CHAR, {25'h0, ch & CHAR_MASK}, 33'h1000000ff, "char");
      rd(ADDR_POWER, {9'h0, cls, cur & CURRENT_MASK, fe}, 33'h100ffffff, "power");
      rd(ADDR_AVAIL, {17'h0, avc}, 33'h10000ffff, "avail");
      apb(1'b1, ADDR_CTRL, 32'h3f);
      rd(ADDR_STATUS, {31'h0, ST_DONE}, 33'h100000003, "status");
      s = {TAG_TEMPLATE, 8'd25, TAG_CHAR, LEN_ONE, ch & CHAR_MASK};
      s = {s, TAG_POWER, LEN_POWER, cls, cur & CURRENT_MASK, fe};
      s = {s, TAG_AVAIL, LEN_SIZE, avc[15:8], avc[7:0]};
      s = {s, TAG_DETAILS, LEN_ONE, det & DETAILS_MASK};
      s = {s, TAG_RESERVED, LEN_SIZE, rs[15:8], rs[7:0]};
      s = {s, TAG_MINCLK, LEN_ONE, e1, TAG_MINCLK, LEN_ONE, e2};
      foreach (s[i]) rd(ADDR_DATA, {24'h0, 1'b1, s[i]}, 33'h1000001ff, "data");
      rd(ADDR_DATA, 33'h0, 33'h100000100, "data end");
      `CHECK("stop", ch[0] ? 2'd3 : ch[2] ? 2'd1 : ch[3] ? 2'd2 : 2'd0, stop)
      `CHECK("current", (cur[5:0] != 6'h0 && cur[5:0] <= 6'h3c), cur_ok)
      `CHECK("minclk", {e1, e2}, {f_first, f_last})
    end
    finish_test();
  end
endmodule // testbench
